// ==== rtl/paemr_regs.sv ====
`timescale 1ns/1ns
module paemr_regs #(
	parameter int CLK_PER_MS = paemr_pkg::CLK_PER_MS
) (
	input wire logic mclk,
	input wire logic nrst,
	input wire logic cke,
	input wire logic soft_rst,
	input wire logic mdc,
	input wire logic mdio_i,
	output logic mdio_o,
	output logic mdio_oe,
	input wire paemr_pkg::paemr_an_ev_t an_ev,
	input wire logic line_energy,
	input wire logic rx_nlp,
	input wire logic auto_crossover_en,
	output logic tx_nlp,
	output logic energy_detect_powerdown_wake,
	output logic energy_detect_powerdown,
	output logic energy_present,
	output logic xover_extend,
	output paemr_pkg::paemr_mode_t mode_cfg
);
	typedef enum logic [2:0] {
		ST_PRE, ST_HDR, ST_TA_RD, ST_RD, ST_TA_WR, ST_WR
	} paemr_st_t;

	localparam int PSW = $clog2(CLK_PER_MS + 1);

	if (CLK_PER_MS < 1) begin : g_bad_clk
		$error("paemr_regs: CLK_PER_MS below 1.");
	end

	// Station management port: pins are synchronised first.
	logic mdc_s;
	logic mdio_s;
	logic mdc_d_r;
	logic mdc_rise;

	paemr_sync #(.W(2)) u_sync (
		.mclk(mclk),
		.nrst(nrst),
		.cke(cke),
		.d({mdc, mdio_i}),
		.q({mdc_s, mdio_s})
	);

	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			mdc_d_r <= 1'b0;
		end else if (cke) begin
			mdc_d_r <= mdc_s;
		end
	end

	assign mdc_rise = mdc_s && !mdc_d_r;

	// Register state.
	logic pdf_r, pdf_nxt;
	logic pr_r, pr_nxt;
	logic [15:0] cfg_r, cfg_nxt;
	logic pden_r, pden_nxt;
	logic spare_r, spare_nxt;
	logic [2:0] mode_r, mode_nxt;
	logic [4:0] addr_r, addr_nxt;
	paemr_pkg::paemr_mode_t mode_cfg_nxt;
	logic xext_nxt;
	logic energy_r, energy_nxt;

	function automatic logic [15:0] rd_mux(input logic [4:0] a);
		logic [15:0] v;
		v = 16'h0000;
		case (a)
			paemr_pkg::REG_AN_EXP: begin
				v[paemr_pkg::EXP_PDF] = pdf_r; // RQ1
				v[paemr_pkg::EXP_LPNP] = an_ev.lp_np_able; // RQ3
				v[paemr_pkg::EXP_NP] = 1'b0; // RQ3
				v[paemr_pkg::EXP_PR] = pr_r; // RQ2
				v[paemr_pkg::EXP_LPAN] = an_ev.lp_an_able; // RQ4
			end
			paemr_pkg::REG_PD_CFG: v = cfg_r;
			paemr_pkg::REG_MODE_CS: begin
				v[paemr_pkg::MCS_PDEN] = pden_r;
				v[paemr_pkg::MCS_EON] = energy_r;
				v[paemr_pkg::MCS_SPARE] = spare_r;
			end
			paemr_pkg::REG_SPECIAL: begin
				v[paemr_pkg::SPM_MODE +: 3] = mode_r;
				v[paemr_pkg::SPM_ADDR +: 5] = addr_r;
			end
			default: v = 16'h0000;
		endcase
		return v;
	endfunction : rd_mux

	// Management frame engine.
	paemr_st_t st_r, st_nxt;
	logic [5:0] cnt_r, cnt_nxt;
	logic [15:0] sh_r, sh_nxt;
	logic [4:0] reg_r, reg_nxt;
	logic mdo_r, mdo_nxt;
	logic oe_r, oe_nxt;
	logic rd_now;
	logic wr_now;
	logic [12:0] hdr;

	always_comb begin
		st_nxt = st_r;
		cnt_nxt = cnt_r;
		sh_nxt = sh_r;
		reg_nxt = reg_r;
		mdo_nxt = mdo_r;
		oe_nxt = oe_r;
		rd_now = 1'b0;
		wr_now = 1'b0;
		hdr = {sh_r[11:0], mdio_s};
		if (mdc_rise) begin
			unique case (st_r)
				ST_PRE: begin
					if (mdio_s) begin
						if (cnt_r != paemr_pkg::PRE_LEN) begin
							cnt_nxt = cnt_r + 6'd1;
						end
					end else if (cnt_r == paemr_pkg::PRE_LEN) begin
						st_nxt = ST_HDR;
						cnt_nxt = 6'd0;
					end else begin
						cnt_nxt = 6'd0;
					end
				end
				ST_HDR: begin
					sh_nxt = {sh_r[14:0], mdio_s};
					cnt_nxt = cnt_r + 6'd1;
					if (cnt_r == paemr_pkg::HDR_LEN - 6'd1) begin
						cnt_nxt = 6'd0;
						reg_nxt = hdr[4:0];
						st_nxt = ST_PRE;
						if (hdr[12] && hdr[9:5] == addr_r) begin // RQ14
							if (hdr[11:10] == paemr_pkg::OP_RD) begin
								st_nxt = ST_TA_RD;
								rd_now = 1'b1;
								sh_nxt = rd_mux(hdr[4:0]);
							end else if (hdr[11:10] == paemr_pkg::OP_WR) begin
								st_nxt = ST_TA_WR;
							end
						end
					end
				end
				ST_TA_RD: begin
					oe_nxt = 1'b1;
					mdo_nxt = 1'b0;
					st_nxt = ST_RD;
				end
				ST_RD: begin
					if (cnt_r == paemr_pkg::DATA_LEN) begin
						oe_nxt = 1'b0;
						mdo_nxt = 1'b0;
						cnt_nxt = 6'd0;
						st_nxt = ST_PRE;
					end else begin
						mdo_nxt = sh_r[15];
						sh_nxt = {sh_r[14:0], 1'b0};
						cnt_nxt = cnt_r + 6'd1;
					end
				end
				ST_TA_WR: begin
					cnt_nxt = cnt_r + 6'd1;
					if (cnt_r == paemr_pkg::TA_LEN - 6'd1) begin
						cnt_nxt = 6'd0;
						st_nxt = ST_WR;
					end
				end
				ST_WR: begin
					sh_nxt = {sh_r[14:0], mdio_s};
					cnt_nxt = cnt_r + 6'd1;
					if (cnt_r == paemr_pkg::DATA_LEN - 6'd1) begin
						wr_now = 1'b1;
						cnt_nxt = 6'd0;
						st_nxt = ST_PRE;
					end
				end
			endcase
		end
	end

	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			st_r <= ST_PRE;
			cnt_r <= 6'd0;
			sh_r <= 16'h0000;
			reg_r <= 5'h00;
			mdo_r <= 1'b0;
			oe_r <= 1'b0;
		end else if (cke) begin
			st_r <= st_nxt;
			cnt_r <= cnt_nxt;
			sh_r <= sh_nxt;
			reg_r <= reg_nxt;
			mdo_r <= mdo_nxt;
			oe_r <= oe_nxt;
		end
	end

	assign mdio_o = mdo_r;
	assign mdio_oe = oe_r;

	// Register file. A new event always beats a read or a soft reset.
	logic rd_exp;
	logic wr_cfg, wr_mcs, wr_spm;

	assign rd_exp = rd_now && (hdr[4:0] == paemr_pkg::REG_AN_EXP);
	assign wr_cfg = wr_now && (reg_r == paemr_pkg::REG_PD_CFG);
	assign wr_mcs = wr_now && (reg_r == paemr_pkg::REG_MODE_CS);
	assign wr_spm = wr_now && (reg_r == paemr_pkg::REG_SPECIAL);

	always_comb begin
		pdf_nxt = an_ev.par_fault || (pdf_r && !rd_exp && !soft_rst); // RQ1 RQ22
		pr_nxt = an_ev.page_rcvd || (pr_r && !rd_exp && !soft_rst); // RQ2 RQ22
		cfg_nxt = cfg_r;
		pden_nxt = pden_r;
		spare_nxt = spare_r;
		mode_nxt = mode_r;
		addr_nxt = addr_r;
		if (soft_rst) begin
			cfg_nxt = paemr_pkg::CFG_RST;
			pden_nxt = 1'b0;
			spare_nxt = 1'b0;
		end else begin
			if (wr_cfg) begin
				cfg_nxt = sh_nxt & paemr_pkg::CFG_WMASK;
			end
			if (wr_mcs) begin
				pden_nxt = sh_nxt[paemr_pkg::MCS_PDEN]; // RQ10
				spare_nxt = sh_nxt[paemr_pkg::MCS_SPARE];
			end
		end
		if (wr_spm) begin // RQ23
			mode_nxt = sh_nxt[paemr_pkg::SPM_MODE +: 3]; // RQ13
			addr_nxt = sh_nxt[paemr_pkg::SPM_ADDR +: 5]; // RQ14
		end
		mode_cfg_nxt = '{speed100: 1'b1, an_en: 1'b1, full_duplex: 1'b1,
			crs_on_tx: 1'b0, repeater: 1'b0, adv: paemr_pkg::ADV_ALL}; // RQ20 RQ21
		unique case (mode_nxt)
			paemr_pkg::MODE_10HD, paemr_pkg::MODE_10FD: begin // RQ15
				mode_cfg_nxt.speed100 = 1'b0;
				mode_cfg_nxt.an_en = 1'b0;
				mode_cfg_nxt.full_duplex = mode_nxt[0];
				mode_cfg_nxt.crs_on_tx = !mode_nxt[0];
			end
			paemr_pkg::MODE_100HD, paemr_pkg::MODE_100FD: begin // RQ16
				mode_cfg_nxt.an_en = 1'b0;
				mode_cfg_nxt.full_duplex = mode_nxt[0];
				mode_cfg_nxt.crs_on_tx = !mode_nxt[0];
			end
			paemr_pkg::MODE_100HD_AN, paemr_pkg::MODE_REPEATER: begin // RQ17 RQ18
				mode_cfg_nxt.full_duplex = 1'b0;
				mode_cfg_nxt.adv = paemr_pkg::ADV_100HD; // RQ21
				mode_cfg_nxt.crs_on_tx = !mode_nxt[0];
				mode_cfg_nxt.repeater = mode_nxt[0];
			end
			default: begin
				mode_cfg_nxt.crs_on_tx = 1'b0;
			end
		endcase
		xext_nxt = auto_crossover_en && !mode_cfg_nxt.an_en
			&& cfg_nxt[paemr_pkg::CFG_XEXT]; // RQ9
	end

	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			pdf_r <= 1'b0;
			pr_r <= 1'b0;
			cfg_r <= paemr_pkg::CFG_RST;
			pden_r <= 1'b0;
			spare_r <= 1'b0;
			mode_r <= paemr_pkg::MODE_RST;
			addr_r <= paemr_pkg::ADDR_RST;
			mode_cfg <= '{speed100: 1'b1, an_en: 1'b1, full_duplex: 1'b1,
				crs_on_tx: 1'b0, repeater: 1'b0, adv: paemr_pkg::ADV_ALL};
			xover_extend <= 1'b0;
		end else if (cke) begin
			pdf_r <= pdf_nxt;
			pr_r <= pr_nxt;
			cfg_r <= cfg_nxt;
			pden_r <= pden_nxt;
			spare_r <= spare_nxt;
			mode_r <= mode_nxt;
			addr_r <= addr_nxt;
			mode_cfg <= mode_cfg_nxt;
			xover_extend <= xext_nxt;
		end
	end

	// Energy-detect power-down engine, timed in milliseconds.
	logic [PSW-1:0] pre_r, pre_nxt;
	logic boot_r;
	logic ms_tick;
	logic in_pd;
	logic tx_go;
	logic tx_busy, tx_done;
	logic win_busy, win_done;
	logic en_busy, en_done;
	logic wake;
	logic win_start;

	assign ms_tick = (pre_r == PSW'(CLK_PER_MS - 1));
	assign in_pd = pden_r && !energy_r; // RQ10
	assign tx_go = in_pd && cfg_r[paemr_pkg::CFG_TXEN]; // RQ5
	assign wake = in_pd && rx_nlp
		&& (cfg_r[paemr_pkg::CFG_RXSGL] || win_busy); // RQ7 RQ8
	assign win_start = in_pd && rx_nlp && !wake;

	always_comb begin
		pre_nxt = ms_tick ? PSW'(0) : pre_r + PSW'(1);
		energy_nxt = energy_r;
		if (line_energy || wake) begin
			energy_nxt = 1'b1;
		end else if (en_done) begin
			energy_nxt = 1'b0; // RQ11
		end
	end

	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			pre_r <= '0;
			boot_r <= 1'b1;
			energy_r <= 1'b1; // RQ12
			tx_nlp <= 1'b0;
			energy_detect_powerdown_wake <= 1'b0;
		end else if (cke) begin
			pre_r <= pre_nxt;
			boot_r <= 1'b0;
			energy_r <= energy_nxt;
			tx_nlp <= tx_done && tx_go; // RQ5
			energy_detect_powerdown_wake <= wake;
		end
	end

	paemr_ms_timer #(.MSW(paemr_pkg::MSW)) u_tx_tmr (
		.mclk(mclk),
		.nrst(nrst),
		.cke(cke),
		.tick(ms_tick),
		.start(tx_go && !tx_busy),
		.stop(!tx_go),
		.load_ms(paemr_pkg::TX_IV_MS[cfg_r[paemr_pkg::CFG_TXIV +: 2]]), // RQ6
		.busy(tx_busy),
		.done(tx_done)
	);

	paemr_ms_timer #(.MSW(paemr_pkg::MSW)) u_win_tmr (
		.mclk(mclk),
		.nrst(nrst),
		.cke(cke),
		.tick(ms_tick),
		.start(win_start),
		.stop(!in_pd || wake),
		.load_ms(paemr_pkg::RX_IV_MS[cfg_r[paemr_pkg::CFG_RXIV +: 2]]), // RQ8
		.busy(win_busy),
		.done(win_done)
	);

	paemr_ms_timer #(.MSW(paemr_pkg::MSW)) u_en_tmr (
		.mclk(mclk),
		.nrst(nrst),
		.cke(cke),
		.tick(ms_tick),
		.start(line_energy || wake || boot_r),
		.stop(1'b0),
		.load_ms(paemr_pkg::ENERGY_MS), // RQ11
		.busy(en_busy),
		.done(en_done)
	);

	assign energy_detect_powerdown = in_pd;
	assign energy_present = energy_r;
endmodule : paemr_regs

// ==== rtl/paemr_pkg.sv ====
// How it works
// RQ1 - Parallel fault flag bit 4 latches high.
// RQ2 - Page received flag bit 1 latches high.
// RQ3 - Next page ability bits 3, 2 read-only.
// RQ4 - Bit 0 shows partner negotiation ability.
// RQ5 - Bit 15 enables periodic pulses in power-down.
// RQ6 - Pulse interval 1s, 768, 512, 256 ms.
// RQ7 - Bit 12 wakes on one received pulse.
// RQ8 - Otherwise two pulses within selected window.
// RQ9 - Bit 0 extends manual crossover 1984 ms.
// RQ10 - Power-down only while bit 13 set.
// RQ11 - Energy bit clears after 256 ms silence.
// RQ12 - Energy bit one on hardware reset only.
// RQ13 - Mode field bits 7:5, default 111b.
// RQ14 - Answer only the matching five-bit address.
// RQ15 - Modes 000b/001b: 10 Mbps, no negotiation.
// RQ16 - Modes 010b/011b: 100 Mbps, no negotiation.
// RQ17 - Mode 100b advertises 100 half only.
// RQ18 - Mode 101b repeater, receive-only carrier sense.
// RQ19 - Master never writes reserved mode 110b.
// RQ20 - Mode 111b negotiates, advertises every ability.
// RQ21 - Advertise bits 8..5: 100FD,100,10FD,10.
// RQ22 - Latched bits clear on read unless active.
// RQ23 - Mode and address survive software reset.
package paemr_pkg;
	localparam logic [4:0] REG_AN_EXP = 5'h06;
	localparam logic [4:0] REG_PD_CFG = 5'h10;
	localparam logic [4:0] REG_MODE_CS = 5'h11;
	localparam logic [4:0] REG_SPECIAL = 5'h12;

	localparam int EXP_PDF = 4;
	localparam int EXP_LPNP = 3;
	localparam int EXP_NP = 2;
	localparam int EXP_PR = 1;
	localparam int EXP_LPAN = 0;
	localparam int CFG_TXEN = 15;
	localparam int CFG_TXIV = 13;
	localparam int CFG_RXSGL = 12;
	localparam int CFG_RXIV = 10;
	localparam int CFG_XEXT = 0;
	localparam int MCS_PDEN = 13;
	localparam int MCS_EON = 1;
	localparam int MCS_SPARE = 0;
	localparam int SPM_MODE = 5;
	localparam int SPM_ADDR = 0;

	localparam logic [15:0] CFG_WMASK = 16'hfc01;
	localparam logic [15:0] CFG_RST = 16'h0000;
	localparam logic [2:0] MODE_RST = 3'h7;
	localparam logic [4:0] ADDR_RST = 5'h01;

	localparam logic [2:0] MODE_10HD = 3'h0;
	localparam logic [2:0] MODE_10FD = 3'h1;
	localparam logic [2:0] MODE_100HD = 3'h2;
	localparam logic [2:0] MODE_100FD = 3'h3;
	localparam logic [2:0] MODE_100HD_AN = 3'h4;
	localparam logic [2:0] MODE_REPEATER = 3'h5;
	localparam logic [3:0] ADV_100HD = 4'h4;
	localparam logic [3:0] ADV_ALL = 4'hf;

	localparam int MSW = 11;
	localparam logic [MSW-1:0] TX_IV_MS [4] = '{11'd1000, 11'd768,
		11'd512, 11'd256};
	localparam logic [MSW-1:0] RX_IV_MS [4] = '{11'd64, 11'd256,
		11'd512, 11'd1000};
	localparam logic [MSW-1:0] ENERGY_MS = 11'd256;
	localparam logic [MSW-1:0] XOVER_EXT_MS = 11'd1984;

	localparam int CLK_PERIOD_NS = 10;
	localparam int MS_NS = 1000000;
	localparam int CLK_PER_MS = MS_NS / CLK_PERIOD_NS;

	localparam logic [5:0] PRE_LEN = 6'd32;
	localparam logic [5:0] HDR_LEN = 6'd13;
	localparam logic [5:0] TA_LEN = 6'd2;
	localparam logic [5:0] DATA_LEN = 6'd16;
	localparam logic [1:0] OP_RD = 2'h2;
	localparam logic [1:0] OP_WR = 2'h1;

	typedef struct packed {
		logic par_fault;
		logic page_rcvd;
		logic lp_np_able;
		logic lp_an_able;
	} paemr_an_ev_t;

	typedef struct packed {
		logic speed100;
		logic an_en;
		logic full_duplex;
		logic crs_on_tx;
		logic repeater;
		logic [3:0] adv;
	} paemr_mode_t;
endpackage : paemr_pkg

// ==== rtl/paemr_sync.sv ====
`timescale 1ns/1ns
module paemr_sync #(
	parameter int W = 2
) (
	input wire logic mclk,
	input wire logic nrst,
	input wire logic cke,
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	logic [W-1:0] meta_r;

	if (W < 1) begin : g_bad_w
		$error("paemr_sync: W must be at least 1.");
	end

	for (genvar i = 0; i < W; i++) begin : g_bit
		always_ff @(posedge mclk or negedge nrst) begin
			if (!nrst) begin
				meta_r[i] <= 1'b0;
				q[i] <= 1'b0;
			end else if (cke) begin
				meta_r[i] <= d[i];
				q[i] <= meta_r[i];
			end
		end
	end
endmodule : paemr_sync

// ==== rtl/paemr_ms_timer.sv ====
`timescale 1ns/1ns
module paemr_ms_timer #(
	parameter int MSW = 11
) (
	input wire logic mclk,
	input wire logic nrst,
	input wire logic cke,
	input wire logic tick,
	input wire logic start,
	input wire logic stop,
	input wire logic [MSW-1:0] load_ms,
	output logic busy,
	output logic done
);
	logic [MSW-1:0] cnt_r;
	logic [MSW-1:0] cnt_nxt;

	if (MSW < 1) begin : g_bad_msw
		$error("paemr_ms_timer: MSW must be at least 1.");
	end

	// Done pulses on the millisecond tick that empties the count.
	assign busy = (cnt_r != '0);
	assign done = tick && (cnt_r == MSW'(1)) && !start && !stop;

	always_comb begin
		cnt_nxt = cnt_r;
		if (start) begin
			cnt_nxt = load_ms;
		end else if (stop) begin
			cnt_nxt = '0;
		end else if (tick && busy) begin
			cnt_nxt = cnt_r - MSW'(1);
		end
	end

	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			cnt_r <= '0;
		end else if (cke) begin
			cnt_r <= cnt_nxt;
		end
	end
endmodule : paemr_ms_timer

// ==== tb/paemr_regs_checker.sv ====
`timescale 1ns/1ns
module paemr_regs_checker #(
	parameter int CLK_PER_MS = 100000
) (
	input wire logic mclk,
	input wire logic nrst,
	input wire logic cke,
	input wire logic mdio_o,
	input wire logic mdio_oe,
	input wire logic line_energy,
	input wire logic rx_nlp,
	input wire logic tx_nlp,
	input wire logic energy_detect_powerdown_wake,
	input wire logic energy_detect_powerdown,
	input wire logic energy_present,
	input wire paemr_pkg::paemr_mode_t mode_cfg
);
	int q_r;
	int q_nxt;
	// Counts enabled cycles since line energy or a wake was last seen.
	always_comb begin
		q_nxt = q_r;
		if (line_energy || energy_detect_powerdown_wake)
			q_nxt = 0;
		else if (cke)
			q_nxt = q_r + 1;
	end
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst)
			q_r <= 0;
		else
			q_r <= q_nxt;
	end
	default clocking @(posedge mclk);
	endclocking
	default disable iff (!nrst);
	a_energy_hold: assert property ($fell(energy_present) |->
		q_r > 255 * CLK_PER_MS - 3) else $error("energy dropped early");
	a_energy_drop: assert property (q_r == 257 * CLK_PER_MS + 2 |->
		!energy_present) else $error("energy kept too long");
	a_energy_rise: assert property (line_energy && cke |=>
		energy_present) else $error("energy not raised");
	a_pd_no_energy: assert property (energy_detect_powerdown_wake |->
		energy_present && !energy_detect_powerdown)
		else $error("power-down kept after wake");
	a_tx_in_pd: assert property (tx_nlp |->
		$past(energy_detect_powerdown) ##1 !tx_nlp)
		else $error("link pulse outside power-down");
	a_wake_cause: assert property (energy_detect_powerdown_wake |->
		($past(rx_nlp) || $past(rx_nlp, 2)) ##1 !energy_detect_powerdown_wake)
		else $error("wake without received pulse");
	a_read_turn: assert property ($rose(mdio_oe) |->
		!mdio_o ##1 mdio_oe [*8]) else $error("bad turnaround");
	a_repeater_cfg: assert property (mode_cfg.repeater |->
		mode_cfg.an_en && mode_cfg.speed100 && !mode_cfg.crs_on_tx &&
		mode_cfg.adv == paemr_pkg::ADV_100HD) else $error("bad repeater");
	a_manual_crs: assert property (!mode_cfg.an_en |->
		mode_cfg.crs_on_tx != mode_cfg.full_duplex)
		else $error("bad carrier sense");
endmodule : paemr_regs_checker
bind paemr_regs paemr_regs_checker #(.CLK_PER_MS(CLK_PER_MS)) i_chk (.mclk,
	.nrst, .cke, .mdio_o, .mdio_oe, .line_energy, .rx_nlp, .tx_nlp,
	.energy_detect_powerdown_wake, .energy_detect_powerdown, .energy_present, .mode_cfg);

// ==== tb/paemr_mdio_master.sv ====
`timescale 1ns/1ns
module paemr_mdio_master #(
	parameter int HALF = 20
) (
	input wire logic mclk,
	input wire logic mdio_o,
	input wire logic mdio_oe,
	output logic mdc,
	output logic mdio_i
);
	logic en_r;
	logic d_r;
	// A released line floats up through the pull-up resistor.
	assign mdio_i = mdio_oe ? mdio_o : (en_r ? d_r : 1'b1);
	initial begin
		mdc = 1'b0;
		en_r = 1'b0;
		d_r = 1'b1;
	end
	task automatic frame(input logic [1:0] op, input logic [4:0] pa,
		input logic [4:0] ra, input logic [15:0] wd,
		output logic [15:0] rd);
		logic [63:0] w;
		w = {32'hffffffff, 2'b01, op, pa, ra, 2'b10, wd};
		rd = '0;
		for (int i = 63; i >= 0; i--) begin
			en_r <= !(op == paemr_pkg::OP_RD && i < 18);
			d_r <= w[i];
			repeat (HALF) @(posedge mclk);
			mdc <= 1'b1;
			if (i < 16)
				rd[i] = mdio_i;
			repeat (HALF) @(posedge mclk);
			mdc <= 1'b0;
		end
		en_r <= 1'b0;
		@(posedge mclk);
	endtask : frame
endmodule : paemr_mdio_master

// ==== tb/paemr_regs_tb.sv ====
`timescale 1ns/1ns
module paemr_regs_tb;
	localparam int CPM = 1;
	logic mclk;
	logic nrst;
	logic soft_rst;
	logic cke;
	logic mdc;
	logic mdio_i;
	logic mdio_o;
	logic mdio_oe;
	paemr_pkg::paemr_an_ev_t an_ev;
	logic line_energy;
	logic rx_nlp;
	logic auto_crossover_en;
	logic tx_nlp;
	logic energy_detect_powerdown_wake;
	logic energy_detect_powerdown;
	logic energy_present;
	logic xover_extend;
	paemr_pkg::paemr_mode_t mode_cfg;
	int errors;
	int num_checks;
	int cyc = 0;
	int n;
	int g;
	logic [4:0] pa;
	logic [15:0] wd;
	logic [15:0] rd;
	paemr_regs #(.CLK_PER_MS(CPM)) i_paemr_regs (.mclk, .nrst, .cke,
		.soft_rst, .mdc, .mdio_i, .mdio_o, .mdio_oe, .an_ev, .line_energy,
		.rx_nlp, .auto_crossover_en, .tx_nlp, .energy_detect_powerdown_wake,
		.energy_detect_powerdown, .energy_present, .xover_extend, .mode_cfg);
	paemr_mdio_master i_paemr_mdio_master (.mclk, .mdio_o, .mdio_oe, .mdc,
		.mdio_i);
	function automatic logic [8:0] mode_val(input logic [2:0] m);
		return {m inside {[3'h2:3'h5]}, m[2], m inside {3'h1, 3'h3},
			m inside {3'h0, 3'h2, 3'h4}, m == 3'h5,
			m == 3'h7 ? paemr_pkg::ADV_ALL : paemr_pkg::ADV_100HD};
	endfunction : mode_val
	function automatic logic [8:0] mode_mask(input logic [2:0] m);
		return m == 3'h7 ? 9'h09f : (m[2] ? 9'h1ff : 9'h1f0);
	endfunction : mode_mask
	task automatic print_verdict();
		$display("checks %0d errors %0d", num_checks, errors);
		if (errors == 0 && num_checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : print_verdict
	task automatic chk(input logic [15:0] got, input logic [15:0] exp,
		input string what);
		num_checks++;
		if (got !== exp) begin
			errors++;
			$display("ERROR %0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask : chk
	task automatic wr(input logic [4:0] ra, input logic [15:0] d);
		i_paemr_mdio_master.frame(paemr_pkg::OP_WR, pa, ra, d, rd);
	endtask : wr
	task automatic rdc(input logic [4:0] ra, input logic [15:0] exp);
		i_paemr_mdio_master.frame(paemr_pkg::OP_RD, pa, ra, 16'h0, rd);
		chk(rd, exp, "read");
	endtask : rdc
	task automatic wait_for(input int k, input int lim);
		n = 0;
		while (n < lim && !(k == 0 ? tx_nlp === 1'b1 : (k == 1 ?
			energy_detect_powerdown_wake === 1'b1 : energy_present === 1'b0))) begin
			@(posedge mclk);
			n++;
		end
	endtask : wait_for
	task automatic nlp();
		rx_nlp <= 1'b1;
		@(posedge mclk);
		rx_nlp <= 1'b0;
	endtask : nlp
	initial begin
		mclk = 1'b0;
		forever #5 mclk = ~mclk;
	end
	always @(posedge mclk) begin
		cyc <= cyc + 1;
		if (cyc == 106000) begin
			errors++;
			print_verdict();
		end
	end
	initial begin
		errors = 0;
		num_checks = 0;
		nrst = 1'b0;
		soft_rst = 1'b0;
		cke = 1'b1;
		an_ev = '0;
		line_energy = 1'b1;
		rx_nlp = 1'b0;
		auto_crossover_en = 1'b0;
		pa = paemr_pkg::ADDR_RST;
		void'($urandom(79393));
		repeat (4) @(posedge mclk);
		chk(16'(energy_present), 16'h1, "energy");
		chk(16'(mode_cfg & mode_mask(3'h7)), 16'(mode_val(3'h7)), "mode");
		nrst <= 1'b1;
		@(posedge mclk);
		rdc(paemr_pkg::REG_PD_CFG, 16'h0000);
		rdc(paemr_pkg::REG_MODE_CS, 16'h0002);
		rdc(paemr_pkg::REG_SPECIAL, 16'h00e1);
		$display("test reset done");
		wd = 16'($urandom);
		wr(paemr_pkg::REG_PD_CFG, wd);
		rdc(paemr_pkg::REG_PD_CFG, wd & paemr_pkg::CFG_WMASK);
		wd = 16'($urandom) & 16'hdfff;
		wr(paemr_pkg::REG_MODE_CS, wd);
		rdc(paemr_pkg::REG_MODE_CS, (wd & 16'h0001) | 16'h0002);
		rdc(5'h1f, 16'h0000);
		pa = 5'h07;
		rdc(paemr_pkg::REG_SPECIAL, 16'hffff);
		pa = paemr_pkg::ADDR_RST;
		wr(paemr_pkg::REG_AN_EXP, 16'hffff);
		an_ev <= 4'b1111;
		@(posedge mclk);
		an_ev <= 4'b0011;
		rdc(paemr_pkg::REG_AN_EXP, 16'h001b);
		rdc(paemr_pkg::REG_AN_EXP, 16'h0009);
		an_ev <= 4'b0000;
		$display("test registers done");
		for (int m = 7; m >= 0; m--) begin
			if (m == 6)
				continue;
			wr(paemr_pkg::REG_SPECIAL, {8'h00, 3'(m), 5'h01});
			wd = 16'(mode_val(3'(m)) & mode_mask(3'(m)));
			chk(16'(mode_cfg & mode_mask(3'(m))), wd,
				"mode");
		end
		auto_crossover_en <= 1'b1;
		wr(paemr_pkg::REG_PD_CFG, 16'h0001);
		chk(16'(xover_extend), 16'h1, "xover");
		auto_crossover_en <= 1'b0;
		repeat (3) @(posedge mclk);
		chk(16'(xover_extend), 16'h0, "xover");
		wr(paemr_pkg::REG_SPECIAL, 16'h00aa);
		pa = 5'h0a;
		soft_rst <= 1'b1;
		@(posedge mclk);
		soft_rst <= 1'b0;
		rdc(paemr_pkg::REG_SPECIAL, 16'h00aa);
		rdc(paemr_pkg::REG_MODE_CS, 16'h0002);
		$display("test modes done");
		wr(paemr_pkg::REG_MODE_CS, 16'h2000);
		// The silence timer must not advance while the clock enable is low.
		line_energy <= 1'b0;
		cke <= 1'b0;
		repeat (300) @(posedge mclk);
		cke <= 1'b1;
		wait_for(2, 700);
		g = paemr_pkg::ENERGY_MS * CPM;
		chk(16'(n >= g - 1 && n <= g + CPM + 1), 16'h1, "quiet");
		chk(16'(energy_detect_powerdown), 16'h1, "pd");
		for (int c = 0; c < 4; c++) begin
			wr(paemr_pkg::REG_PD_CFG, {1'b1, 2'(c), 13'h0000});
			wait_for(0, 1100);
			@(posedge mclk);
			wait_for(0, 1100);
			g = paemr_pkg::TX_IV_MS[c] * CPM;
			chk(16'(n >= g - 1 && n <= g + 2), 16'h1, "tx gap");
		end
		wr(paemr_pkg::REG_PD_CFG, 16'h0000);
		wait_for(0, 1100);
		chk(16'(n), 16'd1100, "no tx");
		$display("test tx pulses done");
		for (int c = 0; c < 4; c++) begin
			wr(paemr_pkg::REG_PD_CFG, {4'h0, 2'(c), 10'h000});
			g = paemr_pkg::RX_IV_MS[c] * CPM;
			nlp();
			repeat (g + 10 + $urandom % 20) @(posedge mclk);
			nlp();
			wait_for(1, g + 20);
			chk(16'(n), 16'(g + 20), "no wake");
			nlp();
			repeat (g - 10 - $urandom % 20) @(posedge mclk);
			nlp();
			wait_for(1, 4);
			chk(16'(n < 4), 16'h1, "pair wake");
		end
		wr(paemr_pkg::REG_PD_CFG, 16'h1000);
		nlp();
		wait_for(1, 4);
		chk(16'(n < 4), 16'h1, "single wake");
		$display("test wake done");
		print_verdict();
	end
endmodule : paemr_regs_tb
